// [pkg/pls_pkg.sv]
// Constants and carrier types for the palette lookup and priority select block.
// Assumes the host MPU port and the pixel source share nothing but the pins.
//
// Functional notes
// - Each 8-bit pixel index maps to a 10-bit value per colour, 30 bits total.
// - Red, green and blue tables are written independently of each other.
// - Up to four devices share outputs; two priority inputs choose the driver.
// - Device is selected only when both priority inputs equal its two match bits.
// - An unselected device forces all colour outputs to zero.
// - Priority inputs travel through the pixel path alongside the pixel index.
// - Select 00 write loads the pointer; 04H-07H reach mask and command registers.
// - Mask FFH passes every pixel index to the tables unaltered.
// - Select 11 writes the mode register directly.
// - Select 01 writes palette entries red, green, blue at the pointer.
// - Command three C0H selects 4:1 multiplexing and clock divided by four.
// - Command two 0CH selects indexed colour, 7.5 IRE pedestal, sync on green.
// - Mode 09H gives normal operation, 8-bit bus, 8-bit lookup resolution.
// - Pipeline reset bit written 1,0,1 returns the pixel phase to the first input.
// - Calibrate bit written 0,1,0 after a pipeline reset resynchronises load timing.
package pls_pkg;
  // ============================================================
  // Register map and select codes
  localparam logic [7:0] PIXEL_INDEX_MASK_IDX = 8'h04;
  localparam logic [7:0] COMMAND_ONE_IDX = 8'h05;
  localparam logic [7:0] COMMAND_TWO_IDX = 8'h06;
  localparam logic [7:0] COMMAND_THREE_IDX = 8'h07;
  localparam logic [1:0] SEL_POINTER = 2'h0;
  localparam logic [1:0] SEL_PALETTE = 2'h1;
  localparam logic [1:0] SEL_INDIRECT = 2'h2;
  localparam logic [1:0] SEL_MODE = 2'h3;
  // ============================================================
  // Field positions
  localparam int MODE_PIPE_RESET_POS = 0;
  localparam int MODE_WIDE_BUS_POS = 1;
  localparam int MODE_CALIBRATE_POS = 5;
  localparam int MODE_MATCH_LOW_POS = 6;
  localparam int MODE_MATCH_HIGH_POS = 7;
  localparam int CMD2_PEDESTAL_POS = 2;
  localparam int CMD2_SYNC_GREEN_POS = 3;
  localparam int CMD3_DIV8_POS = 0;
  localparam int CMD3_MUX_POS = 6;
  localparam logic [1:0] MUX_CODE_4TO1 = 2'h3;
  localparam logic [1:0] MUX_CODE_2TO1 = 2'h2;
  localparam logic [1:0] MUX_LIMIT_4TO1 = 2'h3;
  localparam logic [1:0] MUX_LIMIT_2TO1 = 2'h1;
  localparam logic [1:0] MUX_LIMIT_1TO1 = 2'h0;
  // ============================================================
  // Reset values and timing counts
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'hFF;
  localparam logic [7:0] COMMAND_RESET = 8'h00;
  localparam logic [1:0] DIV4_HALF_CYCLES = 2'h2;
  localparam logic [1:0] DIV8_HALF_CYCLES = 2'h0;
  localparam int PALETTE_DEPTH = 256;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [1:0] {CH_RED, CH_GREEN, CH_BLUE} pls_channel_type;

  typedef struct packed {
    logic prio_high;
    logic prio_low;
    logic [7:0] index;
  } pls_pixel_type;

  typedef struct packed {
    logic [9:0] red;
    logic [9:0] green;
    logic [9:0] blue;
  } pls_rgb_type;
endpackage // pls_pkg

// [design/pls_top.sv]
// Palette lookup with priority select, MPU register port and pixel FIFO.
// Assumes pixel source logic on sys_clk; MPU pins are asynchronous to it.

// ============================================================
// Pixel FIFO
module pls_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  logic ready_r;
  logic push;
  logic pop;

  assign push = in_valid && ready_r;
  assign pop = out_ready && (count_r != '0);
  // Held as a flop so the ready pin leaves a register with no gate after it
  assign in_ready = ready_r;
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];
  assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      ready_r <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_nxt;
      ready_r <= (count_nxt != (AW+1)'(DEPTH));
    end
  end
endmodule // pls_fifo

// ============================================================
// Top
module pls_top #(
  parameter int COLOR_WIDTH = 10,
  parameter int ENTRIES = pls_pkg::PALETTE_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic mpu_strobe,
  input wire logic mpu_read,
  input wire logic register_select_high,
  input wire logic register_select_low,
  input wire logic [9:0] mpu_data_in,
  output logic [9:0] mpu_data_out,
  output logic mpu_data_oe_n,
  input wire logic pixel_valid,
  input wire logic [7:0] pixel_index,
  input wire logic priority_select_low,
  input wire logic priority_select_high,
  output logic pixel_ready,
  input wire logic pixel_load_input,
  output logic pixel_load_output,
  output logic [1:0] pixel_mux_phase,
  output logic [COLOR_WIDTH-1:0] red_output,
  output logic [COLOR_WIDTH-1:0] green_output,
  output logic [COLOR_WIDTH-1:0] blue_output,
  output logic color_valid,
  output logic pedestal_enable,
  output logic sync_on_green,
  output logic programmable_clock_output
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ============================================================
  // MPU strobe synchroniser
  logic [2:0] stb_sync_r;
  logic stb_level_r;
  logic access;
  logic [1:0] sel;
  logic [7:0] wbyte;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stb_sync_r <= 3'h0;
    end else begin
      stb_sync_r <= {stb_sync_r[1:0], mpu_strobe};
    end
  end

  // A strobe counts only once the second and third stage agree
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stb_level_r <= 1'b0;
    end else if (stb_sync_r[1] == stb_sync_r[2]) begin
      stb_level_r <= stb_sync_r[2];
    end
  end

  assign access = stb_sync_r[1] && stb_sync_r[2] && !stb_level_r;
  assign sel = {register_select_high, register_select_low};
  assign wbyte = mpu_data_in[7:0];

  logic wr_ptr_sel;
  logic wr_ind;
  logic wr_mode;
  logic wr_pal;
  assign wr_ptr_sel = access && !mpu_read && sel == pls_pkg::SEL_POINTER;
  assign wr_ind = access && !mpu_read && sel == pls_pkg::SEL_INDIRECT;
  assign wr_mode = access && !mpu_read && sel == pls_pkg::SEL_MODE;
  assign wr_pal = access && !mpu_read && sel == pls_pkg::SEL_PALETTE;

  // ============================================================
  // Registers
  logic [7:0] pointer_r;
  logic [7:0] mode_r;
  logic [7:0] mask_r;
  logic [7:0] cmd1_r;
  logic [7:0] cmd2_r;
  logic [7:0] cmd3_r;
  pls_pkg::pls_channel_type chan_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pointer_r <= 8'h00;
      chan_r <= pls_pkg::CH_RED;
    end else if (wr_ptr_sel) begin
      pointer_r <= wbyte;
      chan_r <= pls_pkg::CH_RED;
    end else if (wr_pal) begin
      unique case (chan_r)
        pls_pkg::CH_RED: chan_r <= pls_pkg::CH_GREEN;
        pls_pkg::CH_GREEN: chan_r <= pls_pkg::CH_BLUE;
        default: begin
          chan_r <= pls_pkg::CH_RED;
          pointer_r <= pointer_r + 8'h01;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mode_r <= pls_pkg::MODE_RESET;
    end else if (wr_mode) begin
      mode_r <= wbyte;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mask_r <= pls_pkg::MASK_RESET;
      cmd1_r <= pls_pkg::COMMAND_RESET;
      cmd2_r <= pls_pkg::COMMAND_RESET;
      cmd3_r <= pls_pkg::COMMAND_RESET;
    end else if (wr_ind) begin
      unique case (pointer_r)
        pls_pkg::PIXEL_INDEX_MASK_IDX: mask_r <= wbyte;
        pls_pkg::COMMAND_ONE_IDX: cmd1_r <= wbyte;
        pls_pkg::COMMAND_TWO_IDX: cmd2_r <= wbyte;
        pls_pkg::COMMAND_THREE_IDX: cmd3_r <= wbyte;
        default: ;
      endcase
    end
  end

  assign pedestal_enable = cmd2_r[pls_pkg::CMD2_PEDESTAL_POS];
  assign sync_on_green = cmd2_r[pls_pkg::CMD2_SYNC_GREEN_POS];

  // ============================================================
  // Palette tables, one per channel so each holds its own curve
  logic [COLOR_WIDTH-1:0] red_tab [ENTRIES];
  logic [COLOR_WIDTH-1:0] green_tab [ENTRIES];
  logic [COLOR_WIDTH-1:0] blue_tab [ENTRIES];
  logic [COLOR_WIDTH-1:0] pal_value;
  logic wide_bus;

  assign wide_bus = mode_r[pls_pkg::MODE_WIDE_BUS_POS];
  // Narrow bus data lands in the top bits of the 10-bit entry
  assign pal_value = wide_bus ? mpu_data_in : {wbyte, 2'b00};

  always_ff @(posedge sys_clk) begin
    if (wr_pal) begin
      unique case (chan_r)
        pls_pkg::CH_RED: red_tab[pointer_r] <= pal_value;
        pls_pkg::CH_GREEN: green_tab[pointer_r] <= pal_value;
        default: blue_tab[pointer_r] <= pal_value;
      endcase
    end
  end

  // ============================================================
  // Read-back and data pin drive
  logic [9:0] rd_value;
  logic [9:0] pal_rd;

  always_comb begin
    unique case (chan_r)
      pls_pkg::CH_RED: pal_rd = red_tab[pointer_r];
      pls_pkg::CH_GREEN: pal_rd = green_tab[pointer_r];
      default: pal_rd = blue_tab[pointer_r];
    endcase
    if (!wide_bus) begin
      pal_rd = {2'b00, pal_rd[9:2]};
    end
    unique case (sel)
      pls_pkg::SEL_POINTER: rd_value = {2'b00, pointer_r};
      pls_pkg::SEL_PALETTE: rd_value = pal_rd;
      pls_pkg::SEL_MODE: rd_value = {2'b00, mode_r};
      default: begin
        unique case (pointer_r)
          pls_pkg::PIXEL_INDEX_MASK_IDX: rd_value = {2'b00, mask_r};
          pls_pkg::COMMAND_ONE_IDX: rd_value = {2'b00, cmd1_r};
          pls_pkg::COMMAND_TWO_IDX: rd_value = {2'b00, cmd2_r};
          pls_pkg::COMMAND_THREE_IDX: rd_value = {2'b00, cmd3_r};
          default: rd_value = 10'h000;
        endcase
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mpu_data_out <= 10'h000;
      mpu_data_oe_n <= 1'b1;
    end else begin
      if (access && mpu_read) begin
        mpu_data_out <= rd_value;
      end
      mpu_data_oe_n <= !(stb_level_r && mpu_read);
    end
  end

  // ============================================================
  // Pipeline reset and load-timing calibration sequences
  logic [1:0] pr_hist_r;
  logic [1:0] cal_hist_r;
  logic cal_armed_r;
  logic pipe_reset;
  logic cal_pulse;

  assign pipe_reset = wr_mode && pr_hist_r == 2'b10 && wbyte[pls_pkg::MODE_PIPE_RESET_POS];
  assign cal_pulse = wr_mode && cal_armed_r && cal_hist_r == 2'b01
                     && !wbyte[pls_pkg::MODE_CALIBRATE_POS];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pr_hist_r <= 2'b00;
      cal_hist_r <= 2'b00;
      cal_armed_r <= 1'b0;
    end else if (wr_mode) begin
      pr_hist_r <= {pr_hist_r[0], wbyte[pls_pkg::MODE_PIPE_RESET_POS]};
      cal_hist_r <= {cal_hist_r[0], wbyte[pls_pkg::MODE_CALIBRATE_POS]};
      // Calibration is honoured only after a completed pipeline reset
      if (pipe_reset) begin
        cal_armed_r <= 1'b1;
      end else if (cal_pulse) begin
        cal_armed_r <= 1'b0;
      end
    end
  end

  // ============================================================
  // Programmable clock divider
  logic [1:0] div_cnt_r;
  logic [1:0] div_half;
  assign div_half = cmd3_r[pls_pkg::CMD3_DIV8_POS] ? pls_pkg::DIV8_HALF_CYCLES
                    : pls_pkg::DIV4_HALF_CYCLES;

  always_ff @(posedge sys_clk) begin
    if (!rst_n || cal_pulse) begin
      div_cnt_r <= 2'h0;
      programmable_clock_output <= 1'b0;
    end else if (div_cnt_r == div_half - 2'h1) begin
      div_cnt_r <= 2'h0;
      programmable_clock_output <= !programmable_clock_output;
    end else begin
      div_cnt_r <= div_cnt_r + 2'h1;
    end
  end

  // ============================================================
  // Pixel path: FIFO, mask, lookup, priority select
  pls_pkg::pls_pixel_type fifo_in;
  pls_pkg::pls_pixel_type fifo_out;
  logic fifo_valid;
  logic drain;
  logic [1:0] mux_limit;
  logic [7:0] masked_idx;
  logic selected;

  assign fifo_in = '{prio_high: priority_select_high, prio_low: priority_select_low,
                     index: pixel_index};
  assign drain = fifo_valid && pixel_load_input;

  pls_fifo #(
    .WIDTH($bits(pls_pkg::pls_pixel_type)),
    .DEPTH(pls_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(pixel_valid),
    .in_ready(pixel_ready),
    .in_data(fifo_in),
    .out_valid(fifo_valid),
    .out_ready(pixel_load_input),
    .out_data(fifo_out)
  );

  always_comb begin
    unique case (cmd3_r[pls_pkg::CMD3_MUX_POS +: 2])
      pls_pkg::MUX_CODE_4TO1: mux_limit = pls_pkg::MUX_LIMIT_4TO1;
      pls_pkg::MUX_CODE_2TO1: mux_limit = pls_pkg::MUX_LIMIT_2TO1;
      default: mux_limit = pls_pkg::MUX_LIMIT_1TO1;
    endcase
  end

  assign masked_idx = fifo_out.index & mask_r;
  assign selected = fifo_out.prio_low == mode_r[pls_pkg::MODE_MATCH_LOW_POS]
                 && fifo_out.prio_high == mode_r[pls_pkg::MODE_MATCH_HIGH_POS];

  always_ff @(posedge sys_clk) begin
    if (!rst_n || pipe_reset) begin
      pixel_mux_phase <= 2'h0;
      pixel_load_output <= 1'b0;
    end else begin
      pixel_load_output <= drain && pixel_mux_phase == 2'h0;
      if (drain) begin
        pixel_mux_phase <= (pixel_mux_phase >= mux_limit) ? 2'h0 : pixel_mux_phase + 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      red_output <= '0;
      green_output <= '0;
      blue_output <= '0;
      color_valid <= 1'b0;
    end else begin
      color_valid <= drain;
      if (drain && selected) begin
        red_output <= red_tab[masked_idx];
        green_output <= green_tab[masked_idx];
        blue_output <= blue_tab[masked_idx];
      end else begin
        red_output <= '0;
        green_output <= '0;
        blue_output <= '0;
      end
    end
  end

  // ============================================================
  // Checks
  chk_unselected_zero: assert property ((drain && !selected) |=>
    red_output == '0 && green_output == '0 && blue_output == '0)
    else $error("unselected pixel drove colour");
  chk_selected_lookup: assert property ((drain && selected) |=>
    green_output == green_tab[$past(masked_idx)] && color_valid)
    else $error("selected pixel not looked up");
  chk_mask_pass: assert property ((drain && mask_r == 8'hFF) |->
    masked_idx == fifo_out.index)
    else $error("full mask altered index");
  chk_ptr_advance: assert property ((wr_pal && chan_r == pls_pkg::CH_BLUE) |=>
    pointer_r == $past(pointer_r) + 8'h01 && chan_r == pls_pkg::CH_RED)
    else $error("pointer did not advance after blue");
  chk_rgb_order: assert property ((wr_pal && chan_r == pls_pkg::CH_RED) |=>
    chan_r == pls_pkg::CH_GREEN && $stable(pointer_r))
    else $error("channel order broken");
  chk_mode_write: assert property (wr_mode |=> mode_r == $past(wbyte))
    else $error("mode register not loaded");
  chk_indirect_write: assert property ((wr_ind && pointer_r == 8'h06) |=>
    cmd2_r == $past(wbyte) && $stable(cmd3_r))
    else $error("indirect write misrouted");
  chk_pipe_reset: assert property (pipe_reset |=> pixel_mux_phase == 2'h0)
    else $error("pipeline reset missed phase");
  chk_cal_resync: assert property (cal_pulse |=> div_cnt_r == 2'h0
    && !programmable_clock_output)
    else $error("calibration did not resync divider");
  chk_div_four: assert property ((cmd3_r == 8'hC0 && !cal_pulse &&
    $rose(programmable_clock_output)) |=> !$changed(programmable_clock_output)
    ##1 $changed(programmable_clock_output) || $past(cal_pulse))
    else $error("clock not divided by four");
endmodule // pls_top

// [dv/pls_pixel_src.sv]
// Pixel source model standing in for the frame buffer side of the pixel port.
// Assumes the bench queues pixels through queue_pixel; one clock, sys_clk.
module pls_pixel_src (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pixel_ready,
  output logic pixel_valid,
  output logic [7:0] pixel_index,
  output logic priority_select_low,
  output logic priority_select_high
);
  timeunit 1ns;
  timeprecision 1ps;
  pls_pkg::pls_pixel_type pend[$];

  task automatic queue_pixel(input pls_pkg::pls_pixel_type p);
    pend.push_back(p);
  endtask

  initial begin
    pixel_valid = 1'b0;
    pixel_index = 8'h00;
    priority_select_low = 1'b0;
    priority_select_high = 1'b0;
  end

  // ============================================================
  // Offer and hold each pixel until taken
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      pend.delete();
      pixel_valid <= 1'b0;
    end else begin
      if (pixel_valid && pixel_ready) begin
        void'(pend.pop_front());
      end
      if (pend.size() > 0) begin
        pixel_valid <= 1'b1;
        // Priority bits ride with their own pixel
        {priority_select_high, priority_select_low, pixel_index} <= pend[0];
      end else begin
        // Idle lines carry junk so a stale value never passes for data
        pixel_valid <= 1'b0;
        pixel_index <= ~pixel_index;
        priority_select_low <= ~priority_select_low;
        priority_select_high <= ~priority_select_high;
      end
    end
  end
endmodule // pls_pixel_src

// [dv/pls_top_test.sv]
// Self-checking bench for the palette lookup block.
// Assumes pls_top with the pixel source model on the pixel port.
module pls_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic mpu_strobe = 1'b0;
  logic mpu_read = 1'b0;
  logic register_select_high = 1'b0;
  logic register_select_low = 1'b0;
  logic [9:0] mpu_data_in = 10'h000;
  logic pixel_load_input = 1'b0;
  logic [9:0] mpu_data_out;
  logic mpu_data_oe_n, pixel_valid, priority_select_low, priority_select_high, pixel_ready;
  logic [7:0] pixel_index;
  logic pixel_load_output, color_valid, pedestal_enable, sync_on_green, programmable_clock_output;
  logic [1:0] pixel_mux_phase;
  logic [9:0] red_output, green_output, blue_output;
  int n_errors = 0;
  int cmp_count = 0;
  logic [29:0] got[$];
  logic [29:0] exp_q[$];
  logic [1:0] first_phase = 2'h3;
  logic first_load = 1'b0;
  logic first_seen = 1'b0;
  logic [9:0] q;
  logic [7:0] init_seq[5] = '{8'h09, 8'h08, 8'h09, 8'h29, 8'h09};
  logic [7:0] reg_idx[4] = '{8'h04, 8'h05, 8'h06, 8'h07};
  logic [7:0] reg_val[4] = '{8'hFF, 8'h00, 8'h0C, 8'hC0};

  always #25 sys_clk = ~sys_clk;

  pls_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .mpu_strobe(mpu_strobe), .mpu_read(mpu_read),
    .register_select_high(register_select_high), .register_select_low(register_select_low),
    .mpu_data_in(mpu_data_in), .mpu_data_out(mpu_data_out), .mpu_data_oe_n(mpu_data_oe_n),
    .pixel_valid(pixel_valid), .pixel_index(pixel_index),
    .priority_select_low(priority_select_low), .priority_select_high(priority_select_high),
    .pixel_ready(pixel_ready), .pixel_load_input(pixel_load_input),
    .pixel_load_output(pixel_load_output), .pixel_mux_phase(pixel_mux_phase),
    .red_output(red_output), .green_output(green_output), .blue_output(blue_output),
    .color_valid(color_valid), .pedestal_enable(pedestal_enable),
    .sync_on_green(sync_on_green), .programmable_clock_output(programmable_clock_output));

  pls_pixel_src src (.sys_clk(sys_clk), .rst_n(rst_n), .pixel_ready(pixel_ready),
    .pixel_valid(pixel_valid), .pixel_index(pixel_index),
    .priority_select_low(priority_select_low), .priority_select_high(priority_select_high));

  // Colour collector; registered outputs are read before this edge updates them
  always @(posedge sys_clk) begin
    if (color_valid === 1'b1) begin
      got.push_back({red_output, green_output, blue_output});
      if (!first_seen) begin
        first_seen = 1'b1;
        first_phase = pixel_mux_phase;
        first_load = pixel_load_output;
      end
    end
  end

  // ============================================================
  // Shared tasks
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [29:0] seen, input logic [29:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, expv, seen);
    end
  endtask

  // Strobe is held six edges: access on the third, data on the fourth, drive on the fifth
  task automatic access(input logic [1:0] sel, input logic rd, input logic [7:0] d);
    @(posedge sys_clk);
    mpu_strobe <= 1'b1;
    mpu_read <= rd;
    {register_select_high, register_select_low} <= sel;
    mpu_data_in <= {2'b00, d};
    repeat (6) @(posedge sys_clk);
    q = mpu_data_out;
    if (rd) check("read drive enable", {29'h0, mpu_data_oe_n}, 30'h0);
    mpu_strobe <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic rd_ind(input logic [7:0] idx, input logic [7:0] expv);
    access(pls_pkg::SEL_POINTER, 1'b0, idx);
    access(pls_pkg::SEL_INDIRECT, 1'b1, 8'h00);
    check("indirect register", {22'h0, q[7:0]}, {22'h0, expv});
  endtask

  function automatic logic [29:0] rgb(input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
    return {r, 2'b00, g, 2'b00, b, 2'b00};
  endfunction

  task automatic px(input logic [7:0] idx, input logic [1:0] prio, input logic [29:0] e);
    @(negedge sys_clk);
    src.queue_pixel({prio, idx});
    exp_q.push_back(e);
  endtask

  task automatic drain_and_compare(input string name);
    for (int i = 0; i < 80 && got.size() < exp_q.size(); i++) @(posedge sys_clk);
    if (got.size() < exp_q.size()) begin
      n_errors++;
      $display("MISMATCH colour count expected %0d seen %0d", exp_q.size(), got.size());
      give_verdict();
    end
    check("colour count", 30'(got.size()), 30'(exp_q.size()));
    foreach (exp_q[i]) check("colour", got[i], exp_q[i]);
    got.delete();
    exp_q.delete();
    $display("Test %s done", name);
  endtask

  // ============================================================
  // Main sequence
  initial begin
    int toggles;
    logic prev;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd_ind(pls_pkg::PIXEL_INDEX_MASK_IDX, 8'hFF);
    $display("Test reset values done");
    foreach (init_seq[i]) access(pls_pkg::SEL_MODE, 1'b0, init_seq[i]);
    foreach (reg_idx[i]) begin
      access(pls_pkg::SEL_POINTER, 1'b0, reg_idx[i]);
      access(pls_pkg::SEL_INDIRECT, 1'b0, reg_val[i]);
    end
    check("pedestal", {29'h0, pedestal_enable}, 30'h1);
    check("sync on green", {29'h0, sync_on_green}, 30'h1);
    foreach (reg_idx[i]) rd_ind(reg_idx[i], reg_val[i]);
    access(pls_pkg::SEL_POINTER, 1'b0, 8'h08);
    access(pls_pkg::SEL_INDIRECT, 1'b0, 8'h55);
    rd_ind(8'h08, 8'h00);
    prev = programmable_clock_output;
    toggles = 0;
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      if (programmable_clock_output !== prev) toggles++;
      prev = programmable_clock_output;
    end
    check("clock toggles", 30'(toggles), 30'h8);
    $display("Test register setup done");
    // Two entries back to back with no pointer reload between them
    access(pls_pkg::SEL_POINTER, 1'b0, 8'h05);
    foreach (reg_val[i]) if (i < 3) access(pls_pkg::SEL_PALETTE, 1'b0, 8'(8'h11 * (i + 1)));
    for (int i = 4; i < 7; i++) access(pls_pkg::SEL_PALETTE, 1'b0, 8'(8'h11 * i));
    access(pls_pkg::SEL_POINTER, 1'b0, 8'h06);
    access(pls_pkg::SEL_PALETTE, 1'b1, 8'h00);
    check("palette read", {22'h0, q[7:0]}, 30'h44);
    $display("Test palette write done");
    pixel_load_input <= 1'b1;
    px(8'h05, 2'b00, rgb(8'h11, 8'h22, 8'h33));
    px(8'h06, 2'b00, rgb(8'h44, 8'h55, 8'h66));
    px(8'h05, 2'b01, 30'h0);
    px(8'h05, 2'b10, 30'h0);
    drain_and_compare("priority match zero");
    // The phase register already points at the next input once the first pixel is taken
    check("first phase", {28'h0, first_phase}, 30'h1);
    check("first load pulse", {29'h0, first_load}, 30'h1);
    access(pls_pkg::SEL_MODE, 1'b0, 8'hC9);
    px(8'h06, 2'b11, rgb(8'h44, 8'h55, 8'h66));
    px(8'h06, 2'b00, 30'h0);
    access(pls_pkg::SEL_POINTER, 1'b0, 8'h04);
    access(pls_pkg::SEL_INDIRECT, 1'b0, 8'hFE);
    px(8'h07, 2'b11, rgb(8'h44, 8'h55, 8'h66));
    drain_and_compare("priority match three");
    // Fill the FIFO past its depth with the drain held off
    pixel_load_input <= 1'b0;
    // Mask FE is still set, so index 07 folds onto the written entry 06
    for (int i = 0; i < 9; i++) px(8'h07, 2'b11, rgb(8'h44, 8'h55, 8'h66));
    repeat (12) @(posedge sys_clk);
    check("pixel ready when full", {29'h0, pixel_ready}, 30'h0);
    pixel_load_input <= 1'b1;
    drain_and_compare("fifo fill");
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    $display("MISMATCH run time expected end seen timeout");
    give_verdict();
  end
endmodule // pls_top_test
